// File: rtl/bre_pkg.sv
package bre_pkg;

  // Instruction word layout: opcode, operand field, compare relation
  localparam int OPC_W      = 5;
  localparam int OPC_LSB    = 27;
  localparam int ADDR_W     = 10;
  localparam int ADDR_LSB   = 0;
  localparam int BIT_W      = 5;
  localparam int BIT_LSB    = 10;
  localparam int CONST_W    = 16;
  localparam int CONST_LSB  = 10;
  localparam int INSTR_W    = 32;

  // Operand spaces: top two address bits select the point group
  localparam logic [1:0] SPACE_IN    = 2'h0;  // Inputs, octal 0-377
  localparam logic [1:0] SPACE_OUT   = 2'h1;  // Outputs, octal 0-377
  localparam logic [1:0] SPACE_MEM   = 2'h2;  // Relays, stages; timers use space code 3

  // Largest octal point numbers per space
  localparam logic [9:0] MAX_IO_PT   = 10'h0ff;  // Octal 377
  localparam logic [9:0] MAX_RELAY   = 10'h1ff;  // Octal 777
  localparam logic [9:0] MAX_TMR     = 10'h07f;  // Octal 177
  localparam logic [4:0] MAX_BIT_BCD = 5'h15;    // BCD 15

  // Boolean stack depth
  localparam int STACK_DEPTH = 8;

  // Wait for physical point access, in ns, and derived cycles at 20 MHz
  localparam int CLK_PERIOD_NS  = 50;
  localparam int IMM_ACCESS_NS  = 100;
  localparam int IMM_ACCESS_CYC =
    (IMM_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Reset values
  localparam logic [9:0] PC_RESET = 10'h000;

  // Instruction opcodes
  typedef enum logic [4:0] {
    OP_NOP          = 5'h00,
    OP_LOAD_NO      = 5'h01,  // load_normally_open
    OP_LOAD_NC      = 5'h02,  // load_normally_closed
    OP_SERIES       = 5'h03,
    OP_SERIES_INV   = 5'h04,
    OP_PARALLEL     = 5'h05,
    OP_PARALLEL_INV = 5'h06,  // parallel_inverted_contact
    OP_COIL         = 5'h07,
    OP_MERGE_PAR    = 5'h08,  // branch_parallel_merge
    OP_MERGE_SER    = 5'h09,  // branch_series_merge
    OP_LOAD_WB      = 5'h0a,  // load_word_bit
    OP_LOAD_WB_INV  = 5'h0b,  // load_inverted_word_bit
    OP_CMP_LOAD     = 5'h0c,
    OP_CMP_SERIES   = 5'h0d,
    OP_IMM_LOAD     = 5'h0e,
    OP_IMM_SERIES   = 5'h0f,
    OP_IMM_COIL     = 5'h10,
    OP_RUNG_START   = 5'h11,
    OP_END          = 5'h1f
  } bre_op_e;

  // Compare relations
  typedef enum logic [1:0] {
    REL_EQ = 2'h0,
    REL_NE = 2'h1,
    REL_GE = 2'h2,
    REL_LT = 2'h3
  } bre_rel_e;

endpackage : bre_pkg

// File: rtl/bre_compare.sv
`timescale 1ns/1ps
// Four-digit BCD comparator for comparative contacts
module bre_compare (
  // Operands
  input  wire logic [15:0] a_in,
  input  wire logic [15:0] b_in,
  input  wire logic [1:0]  rel_in,
  // Result
  output logic             true_out
);

  // BCD digits order like binary when every digit is valid
  always_comb begin
    case (bre_pkg::bre_rel_e'(rel_in))
      bre_pkg::REL_EQ: true_out = (a_in == b_in);
      bre_pkg::REL_NE: true_out = (a_in != b_in);
      bre_pkg::REL_GE: true_out = (a_in >= b_in);
      bre_pkg::REL_LT: true_out = (a_in < b_in);
      default:         true_out = 1'b0;
    endcase
  end

endmodule : bre_compare

// File: rtl/bre_evaluator.sv
`timescale 1ns/1ps
// Function
// - End instruction finishes the scan; later instructions are not run.
// - Normally open load pushes the referenced point value.
// - Normally closed load pushes the inverse of the point value.
// - Series contact ANDs its value into the top of stack.
// - After a midline coil, series contacts continue the same rung.
// - Parallel contact ORs the true point value into the top.
// - Parallel inverted contact ORs the inverted value into the top.
// - Coil writes the top of stack to the output point.
// - Parallel merge ORs the top two stack levels.
// - Series merge ANDs the top two stack levels.
// - Eight-level stack; loads push and shift older entries down.
// - Merges fold top two levels into one, depth minus one.
// - Rung needing more than eight levels is flagged and not executed; here its instructions before the overflowing load still run.
// - Compare two four-digit values: EQ, NE, GE or LT; here the constant's top bit doubles as the relation's low bit.
// - Immediate access stalls execution until the point access completes.
// - Immediate input read leaves the input image untouched.
// - Every immediate input instruction reads the physical pin anew.
// - Immediate output drives the pin and updates the output image.
// - Octal point ranges: I/O 0-377, relays 0-777, timers 0-177; relay space here only reaches 0-377.
// - Word-bit load takes a BCD-selected bit 0 to 15 of a word.
// - Inverted word-bit load pushes the inverse of that bit.
module bre_evaluator #(
  parameter int N_IN  = 256,
  parameter int N_OUT = 256,
  parameter int N_MEM = 512
) (
  // Clock and reset
  input  wire logic        CLK_IN,
  input  wire logic        RESETN_IN,
  // Scan control
  input  wire logic        SCAN_START_IN,
  output logic             SCAN_DONE_OUT,
  output logic             BUSY_OUT,
  // Program memory
  output logic [9:0]       PMEM_ADDR_OUT,
  input  wire logic [31:0] PMEM_DATA_IN,
  // Word memory, read by word-bit and compare contacts
  output logic [9:0]       WMEM_ADDR_OUT,
  input  wire logic [15:0] WMEM_DATA_IN,
  // Input image, loaded by the I/O update outside this block
  input  wire logic [N_IN-1:0] IN_IMAGE_IN,
  // Physical pins
  input  wire logic [N_IN-1:0] PHYS_IN,
  output logic [N_OUT-1:0] PHYS_OUT,
  // Images
  output logic [N_OUT-1:0] OUT_IMAGE_OUT,
  output logic [N_MEM-1:0] MEM_BITS_OUT,
  // Status
  output logic             STACK_ERR_OUT,
  output logic             RANGE_ERR_OUT
);

  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_FETCH = 3'h1,
    ST_EXEC  = 3'h2,
    ST_WAIT  = 3'h3,
    ST_SKIP  = 3'h4
  } bre_state_e;

  bre_state_e              state_q;
  logic [9:0]              pc_q;
  logic [31:0]             ir_q;
  logic [7:0]              stk_q;
  logic [3:0]              depth_q;
  logic [2:0]              wait_q;
  logic [N_IN-1:0]         phys_s1_q;
  logic [N_IN-1:0]         phys_s2_q;
  logic [N_OUT-1:0]        out_img_q;
  logic [N_OUT-1:0]        phys_q;
  logic [N_MEM-1:0]        mem_q;
  logic                    stk_err_q;
  logic                    rng_err_q;

  // Instruction fields
  bre_pkg::bre_op_e        op;
  logic [1:0]              space;
  logic [7:0]              pt;
  logic [9:0]              addr;
  logic [4:0]              bit_bcd;
  logic [3:0]              bit_idx;
  logic [15:0]             kval;
  logic [1:0]              rel;
  logic                    cmp_true;
  logic                    img_val;
  logic                    val;
  logic                    in_range;
  logic                    is_load;
  logic                    is_merge;
  logic                    is_imm;

  assign op      = bre_pkg::bre_op_e'(ir_q[bre_pkg::OPC_LSB +: bre_pkg::OPC_W]);
  assign addr    = ir_q[bre_pkg::ADDR_LSB +: bre_pkg::ADDR_W];
  assign space   = addr[9:8];
  assign pt      = addr[7:0];
  assign bit_bcd = ir_q[bre_pkg::BIT_LSB +: bre_pkg::BIT_W];
  assign kval    = ir_q[bre_pkg::CONST_LSB +: bre_pkg::CONST_W];
  assign rel     = ir_q[26:25];

  // BCD bit index: tens digit is bit 4 of the field
  assign bit_idx = bit_bcd[4] ? 4'(4'ha + {1'b0, bit_bcd[2:0]})
                              : bit_bcd[3:0];

  // Comparator for comparative contacts
  bre_compare u_cmp (
    .a_in     (WMEM_DATA_IN),
    .b_in     (kval),
    .rel_in   (rel),
    .true_out (cmp_true)
  );

  // Operand range check on octal point numbers
  always_comb begin
    case (op)
      bre_pkg::OP_LOAD_WB, bre_pkg::OP_LOAD_WB_INV:
        in_range = (bit_bcd <= bre_pkg::MAX_BIT_BCD) &&
                   (bit_bcd[3:0] <= 4'h9);
      bre_pkg::OP_CMP_LOAD, bre_pkg::OP_CMP_SERIES:
        in_range = 1'b1;
      default:
        case (space)
          bre_pkg::SPACE_IN, bre_pkg::SPACE_OUT:
            in_range = 1'b1;
          bre_pkg::SPACE_MEM:
            in_range = (addr[8:0] <= bre_pkg::MAX_RELAY[8:0]);
          default:
            in_range = (addr[6:0] <= bre_pkg::MAX_TMR[6:0]) &&
                       (addr[7] == 1'b0);
        endcase
    endcase
  end

  // Image value of the referenced point; timer space shares memory bits
  always_comb begin
    case (space)
      bre_pkg::SPACE_IN:  img_val = IN_IMAGE_IN[pt];
      bre_pkg::SPACE_OUT: img_val = out_img_q[pt];
      default:            img_val = mem_q[addr[8:0]];
    endcase
  end

  // Contact value for the current instruction
  always_comb begin
    case (op)
      bre_pkg::OP_LOAD_NC, bre_pkg::OP_SERIES_INV,
      bre_pkg::OP_PARALLEL_INV:
        val = ~img_val;
      bre_pkg::OP_LOAD_WB:     val = WMEM_DATA_IN[bit_idx];
      bre_pkg::OP_LOAD_WB_INV: val = ~WMEM_DATA_IN[bit_idx];
      bre_pkg::OP_CMP_LOAD, bre_pkg::OP_CMP_SERIES:
        val = cmp_true;
      bre_pkg::OP_IMM_LOAD, bre_pkg::OP_IMM_SERIES:
        val = phys_s2_q[pt];
      default:                 val = img_val;
    endcase
  end

  assign is_load  = (op == bre_pkg::OP_LOAD_NO) ||
                    (op == bre_pkg::OP_LOAD_NC) ||
                    (op == bre_pkg::OP_LOAD_WB) ||
                    (op == bre_pkg::OP_LOAD_WB_INV) ||
                    (op == bre_pkg::OP_CMP_LOAD) ||
                    (op == bre_pkg::OP_IMM_LOAD);
  assign is_merge = (op == bre_pkg::OP_MERGE_PAR) ||
                    (op == bre_pkg::OP_MERGE_SER);
  assign is_imm   = (op == bre_pkg::OP_IMM_LOAD) ||
                    (op == bre_pkg::OP_IMM_SERIES) ||
                    (op == bre_pkg::OP_IMM_COIL);

  // Physical inputs cross in through two flops; the pins are asynchronous
  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      phys_s1_q <= '0;
      phys_s2_q <= '0;
    end else begin
      phys_s1_q <= PHYS_IN;
      phys_s2_q <= phys_s1_q;
    end
  end

  // Sequencer: fetch, execute, stall on immediate access, skip bad rung
  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      state_q <= ST_IDLE;
      pc_q    <= bre_pkg::PC_RESET;
      ir_q    <= '0;
      wait_q  <= '0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (SCAN_START_IN) begin
            pc_q    <= bre_pkg::PC_RESET;
            state_q <= ST_FETCH;
          end
        end
        ST_FETCH: begin
          ir_q    <= PMEM_DATA_IN;
          pc_q    <= 10'(pc_q + 10'h001);
          state_q <= ST_EXEC;
        end
        ST_EXEC: begin
          // Faults are caught before any pin wait, so immediate loads skip too
          if (op == bre_pkg::OP_END) begin
            state_q <= ST_IDLE;
          end else if ((is_load && depth_q == 4'(bre_pkg::STACK_DEPTH)) ||
                       !in_range) begin
            state_q <= ST_SKIP;
          end else if (is_imm) begin
            wait_q  <= 3'(bre_pkg::IMM_ACCESS_CYC);
            state_q <= ST_WAIT;
          end else begin
            state_q <= ST_FETCH;
          end
        end
        ST_WAIT: begin
          // Pin access still in flight: hold the program where it is
          if (wait_q == 3'h1) begin
            state_q <= ST_FETCH;
          end
          wait_q <= 3'(wait_q - 3'h1);
        end
        ST_SKIP: begin
          // Discard the rest of the faulty rung up to the next rung start
          ir_q <= PMEM_DATA_IN;
          pc_q <= 10'(pc_q + 10'h001);
          if (PMEM_DATA_IN[bre_pkg::OPC_LSB +: bre_pkg::OPC_W] ==
              bre_pkg::OP_RUNG_START ||
              PMEM_DATA_IN[bre_pkg::OPC_LSB +: bre_pkg::OPC_W] ==
              bre_pkg::OP_END) begin
            state_q <= ST_EXEC;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Execute point: immediate ops act when their wait ends
  logic exec_now;
  assign exec_now = ((state_q == ST_EXEC) && !is_imm) ||
                    ((state_q == ST_WAIT) && (wait_q == 3'h1));

  // Boolean stack: bit 0 is the top
  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      stk_q   <= '0;
      depth_q <= '0;
    end else if (state_q == ST_IDLE && SCAN_START_IN) begin
      stk_q   <= '0;
      depth_q <= '0;
    end else if (exec_now && in_range) begin
      case (op)
        bre_pkg::OP_RUNG_START: begin
          stk_q   <= '0;
          depth_q <= '0;
        end
        bre_pkg::OP_LOAD_NO, bre_pkg::OP_LOAD_NC, bre_pkg::OP_LOAD_WB,
        bre_pkg::OP_LOAD_WB_INV, bre_pkg::OP_CMP_LOAD,
        bre_pkg::OP_IMM_LOAD: begin
          if (depth_q < 4'(bre_pkg::STACK_DEPTH)) begin
            stk_q   <= {stk_q[6:0], val};
            depth_q <= 4'(depth_q + 4'h1);
          end
        end
        bre_pkg::OP_SERIES, bre_pkg::OP_SERIES_INV,
        bre_pkg::OP_CMP_SERIES, bre_pkg::OP_IMM_SERIES:
          stk_q[0] <= stk_q[0] & val;
        bre_pkg::OP_PARALLEL, bre_pkg::OP_PARALLEL_INV:
          stk_q[0] <= stk_q[0] | val;
        bre_pkg::OP_MERGE_PAR, bre_pkg::OP_MERGE_SER: begin
          if (depth_q >= 4'h2) begin
            stk_q <= {1'b0, stk_q[7:2],
                      (op == bre_pkg::OP_MERGE_PAR) ?
                      (stk_q[1] | stk_q[0]) :
                      (stk_q[1] & stk_q[0])};
            depth_q <= 4'(depth_q - 4'h1);
          end
        end
        default: ;
      endcase
    end
  end

  // Coils: top of stack is kept, so later contacts extend the rung
  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      out_img_q <= '0;
      phys_q    <= '0;
      mem_q     <= '0;
    end else if (exec_now && in_range) begin
      if (op == bre_pkg::OP_COIL) begin
        if (space == bre_pkg::SPACE_OUT) begin
          out_img_q[pt] <= stk_q[0];
        end else if (space == bre_pkg::SPACE_MEM) begin
          mem_q[addr[8:0]] <= stk_q[0];
        end
      end else if (op == bre_pkg::OP_IMM_COIL) begin
        phys_q[pt]    <= stk_q[0];
        out_img_q[pt] <= stk_q[0];
      end
    end
  end

  // Error flags: sticky for the scan, cleared by the next scan start
  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      stk_err_q <= 1'b0;
      rng_err_q <= 1'b0;
    end else if (state_q == ST_EXEC && is_load &&
                 depth_q == 4'(bre_pkg::STACK_DEPTH)) begin
      stk_err_q <= 1'b1;
    end else if (state_q == ST_EXEC && !in_range) begin
      rng_err_q <= 1'b1;
    end else if (state_q == ST_IDLE && SCAN_START_IN) begin
      stk_err_q <= 1'b0;
      rng_err_q <= 1'b0;
    end
  end

  // Done pulse on the end instruction
  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      SCAN_DONE_OUT <= 1'b0;
    end else begin
      SCAN_DONE_OUT <= (state_q == ST_EXEC) && (op == bre_pkg::OP_END);
    end
  end

  assign BUSY_OUT      = (state_q != ST_IDLE);
  assign PMEM_ADDR_OUT = pc_q;
  assign WMEM_ADDR_OUT = addr;
  assign OUT_IMAGE_OUT = out_img_q;
  assign PHYS_OUT      = phys_q;
  assign MEM_BITS_OUT  = mem_q;
  assign STACK_ERR_OUT = stk_err_q;
  assign RANGE_ERR_OUT = rng_err_q;

endmodule : bre_evaluator

// File: testbench/bre_evaluator_assertions.sv
`timescale 1ns/1ps
// Port-level checks on the scan handshake, image stability and error flags
module bre_evaluator_assertions #(
  parameter int N_OUT = 256,
  parameter int N_MEM = 512
) (
  // Clock and reset
  input  wire logic             CLK_IN,
  input  wire logic             RESETN_IN,
  // Scan control and program address
  input  wire logic             SCAN_START_IN,
  input  wire logic             SCAN_DONE_OUT,
  input  wire logic             BUSY_OUT,
  input  wire logic [9:0]       PMEM_ADDR_OUT,
  // Images and status
  input  wire logic [N_OUT-1:0] OUT_IMAGE_OUT,
  input  wire logic [N_MEM-1:0] MEM_BITS_OUT,
  input  wire logic             STACK_ERR_OUT,
  input  wire logic             RANGE_ERR_OUT
);
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RESETN_IN);

  // A start request only counts while the evaluator is idle
  wire logic take = SCAN_START_IN && !BUSY_OUT;

  // Scan handshake: start, first fetch and the closing pulse
  done_one_cycle_a: assert property (SCAN_DONE_OUT |=> !SCAN_DONE_OUT)
    else $error("Done pulse lasted more than one cycle");
  done_idle_a: assert property (SCAN_DONE_OUT |-> !BUSY_OUT)
    else $error("Done pulse while still busy");
  end_done_a: assert property ($fell(BUSY_OUT) |-> SCAN_DONE_OUT)
    else $error("Busy dropped without a done pulse");
  start_busy_a: assert property (take |=> BUSY_OUT [*2])
    else $error("Accepted start did not hold busy for a fetch and exec");
  start_addr_a: assert property (take |=> PMEM_ADDR_OUT == 10'h000)
    else $error("Scan did not fetch from address zero");

  // Images only move while a program runs; a trade-off: idle writes unseen
  out_idle_a: assert property ((!BUSY_OUT && !SCAN_START_IN) |=>
    $stable(OUT_IMAGE_OUT))
    else $error("Output image changed while idle");
  mem_idle_a: assert property ((!BUSY_OUT && !SCAN_START_IN) |=>
    $stable(MEM_BITS_OUT))
    else $error("Memory bits changed while idle");

  // Error flags clear only shortly after a new scan is taken
  stack_sticky_a: assert property ($fell(STACK_ERR_OUT) |->
    ($past(take, 1) || $past(take, 2)))
    else $error("Stack error cleared outside a scan start");
  range_sticky_a: assert property ($fell(RANGE_ERR_OUT) |->
    ($past(take, 1) || $past(take, 2)))
    else $error("Range error cleared outside a scan start");
endmodule : bre_evaluator_assertions

bind bre_evaluator bre_evaluator_assertions #(
  .N_OUT(N_OUT),
  .N_MEM(N_MEM)
) bre_evaluator_assertions_inst (
  .CLK_IN       (CLK_IN),
  .RESETN_IN    (RESETN_IN),
  .SCAN_START_IN(SCAN_START_IN),
  .SCAN_DONE_OUT(SCAN_DONE_OUT),
  .BUSY_OUT     (BUSY_OUT),
  .PMEM_ADDR_OUT(PMEM_ADDR_OUT),
  .OUT_IMAGE_OUT(OUT_IMAGE_OUT),
  .MEM_BITS_OUT (MEM_BITS_OUT),
  .STACK_ERR_OUT(STACK_ERR_OUT),
  .RANGE_ERR_OUT(RANGE_ERR_OUT)
);

// File: testbench/bre_partner.sv
`timescale 1ns/1ps
// Program store and word memory; both answer in the same cycle
module bre_partner (
  // Program memory
  input  wire logic [9:0]  pmem_addr_in,
  output logic      [31:0] pmem_data_out,
  // Word memory
  input  wire logic [9:0]  wmem_addr_in,
  output logic      [15:0] wmem_data_out
);
  logic [31:0] prog  [32];
  logic [15:0] words [4];

  // Unmapped places read as end of program or zero, never as stale data
  assign pmem_data_out = (pmem_addr_in < 10'h020) ?
    prog[pmem_addr_in[4:0]] : {bre_pkg::OP_END, 27'h0000000};
  assign wmem_data_out = (wmem_addr_in < 10'h004) ?
    words[wmem_addr_in[1:0]] : 16'h0000;
endmodule : bre_partner

// File: testbench/tb_bre_evaluator.sv
`timescale 1ns/1ps
// Table of one-rung programs, then stack, immediate and range cases
module tb_bre_evaluator;
  localparam logic [4:0] RS = bre_pkg::OP_RUNG_START, EN = bre_pkg::OP_END;
  localparam logic [4:0] LD = bre_pkg::OP_LOAD_NO, LN = bre_pkg::OP_LOAD_NC;
  localparam logic [4:0] SE = bre_pkg::OP_SERIES, SN = bre_pkg::OP_SERIES_INV;
  localparam logic [4:0] PA = bre_pkg::OP_PARALLEL;
  localparam logic [4:0] PN = bre_pkg::OP_PARALLEL_INV, CO = bre_pkg::OP_COIL;
  localparam logic [4:0] MP = bre_pkg::OP_MERGE_PAR, MS = bre_pkg::OP_MERGE_SER;
  localparam logic [4:0] WB = bre_pkg::OP_LOAD_WB, WN = bre_pkg::OP_LOAD_WB_INV;
  localparam logic [4:0] CL = bre_pkg::OP_CMP_LOAD, CS = bre_pkg::OP_CMP_SERIES;
  localparam logic [4:0] IL = bre_pkg::OP_IMM_LOAD, IC = bre_pkg::OP_IMM_COIL;
  localparam logic [4:0] IS = bre_pkg::OP_IMM_SERIES;
  // Word addresses reuse the same operand codes as inputs
  localparam logic [9:0] X0 = 10'h000, X1 = 10'h001, X2 = 10'h002;
  localparam logic [9:0] Y0 = 10'h100, Y1 = 10'h101;
  localparam logic [31:0] NP = 32'h00000000;

  typedef struct packed {
    logic [31:0] i0, i1, i2, i3;
    logic [2:0]  img;
    logic [1:0]  y;
  } bre_row_s;

  logic         clk = 1'b0;
  logic         rst_n;
  logic         start;
  logic         done, busy, stk_err, rng_err;
  logic [9:0]   paddr, waddr;
  logic [31:0]  pdata;
  logic [15:0]  wdata;
  logic [255:0] in_img, phys_in, phys_out, out_img;
  logic [511:0] mem_bits;
  bre_row_s     rows [20];
  logic [31:0]  q [$];
  int           n_mismatch = 0;
  int           check_count = 0;

  always #25 clk = ~clk;

  bre_evaluator bre_evaluator_inst (
    .CLK_IN(clk), .RESETN_IN(rst_n), .SCAN_START_IN(start),
    .SCAN_DONE_OUT(done), .BUSY_OUT(busy), .PMEM_ADDR_OUT(paddr),
    .PMEM_DATA_IN(pdata), .WMEM_ADDR_OUT(waddr), .WMEM_DATA_IN(wdata),
    .IN_IMAGE_IN(in_img), .PHYS_IN(phys_in), .PHYS_OUT(phys_out),
    .OUT_IMAGE_OUT(out_img), .MEM_BITS_OUT(mem_bits),
    .STACK_ERR_OUT(stk_err), .RANGE_ERR_OUT(rng_err));
  bre_partner bre_partner_inst (.pmem_addr_in(paddr), .pmem_data_out(pdata),
    .wmem_addr_in(waddr), .wmem_data_out(wdata));

  function automatic logic [31:0] mk(logic [4:0] op, logic [16:0] f,
                                     logic [9:0] a);
    return {op, f, a};
  endfunction : mk

  function automatic logic [31:0] ins(logic [4:0] op, logic [9:0] a);
    return mk(op, 17'h00000, a);
  endfunction : ins

  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : wrap_up

  // Loads q, a canary rung behind the end word, runs one scan; m is the
  // count of immediate words, negative when skipping makes timing open
  task automatic scan(input int m);
    int n, exp_n;
    for (int a = 0; a < 32; a++) begin
      bre_partner_inst.prog[a] = ins(EN, X0);
    end
    foreach (q[a]) bre_partner_inst.prog[a] = q[a];
    bre_partner_inst.prog[q.size() + 1] = ins(RS, X0);
    bre_partner_inst.prog[q.size() + 2] = ins(LN, 10'h0ff);
    bre_partner_inst.prog[q.size() + 3] = ins(CO, 10'h104);
    start = 1'b1;
    n = 0;
    do begin
      @(negedge clk);
      if (n == 0) start = 1'b0;
      n++;
    end while (done !== 1'b1 && n < 600);
    if (n >= 600) begin
      n_mismatch++;
      wrap_up();
    end
    exp_n = 2 * (q.size() + 1) + bre_pkg::IMM_ACCESS_CYC * m + 1;
    if (m >= 0) check("scan cycles", 32'(n), 32'(exp_n));
  endtask : scan

  initial begin
    rst_n = 1'b0;
    start = 1'b0;
    in_img = '0;
    phys_in = '0;
    bre_partner_inst.words = '{16'h1000, 16'h1234, 16'h9300, 16'h0000};
    rows[0] = '{ins(LD, X0), NP, NP, NP, 3'h1, 2'h1};
    rows[1] = '{ins(LN, X0), NP, NP, NP, 3'h1, 2'h0};
    rows[2] = '{ins(LN, X0), NP, NP, NP, 3'h0, 2'h1};
    rows[3] = '{ins(LD, X0), ins(SE, X1), NP, NP, 3'h1, 2'h0};
    rows[4] = '{ins(LD, X0), ins(SE, X1), NP, NP, 3'h3, 2'h1};
    rows[5] = '{ins(LD, X0), ins(SN, X1), NP, NP, 3'h1, 2'h1};
    rows[6] = '{ins(LD, X0), ins(PA, X1), NP, NP, 3'h2, 2'h1};
    rows[7] = '{ins(LD, X0), ins(PN, X1), NP, NP, 3'h2, 2'h0};
    rows[8] = '{ins(LD, X0), ins(PN, X1), NP, NP, 3'h0, 2'h1};
    rows[9] = '{ins(LD, X0), ins(SE, X1), ins(LD, X2), ins(MP, X0),
                3'h4, 2'h1};
    rows[10] = '{ins(LD, X0), ins(LD, X1), ins(PA, X2), ins(MS, X0),
                 3'h5, 2'h1};
    rows[11] = '{ins(LD, X0), ins(LD, X1), ins(PA, X2), ins(MS, X0),
                 3'h1, 2'h0};
    rows[12] = '{mk(WB, 17'h00012, X0), NP, NP, NP, 3'h0, 2'h1};
    rows[13] = '{mk(WN, 17'h00012, X0), NP, NP, NP, 3'h0, 2'h0};
    rows[14] = '{mk(CL, 17'h01234, X1), NP, NP, NP, 3'h0, 2'h1};
    rows[15] = '{mk(CL, 17'h09234, X1), NP, NP, NP, 3'h0, 2'h1};
    rows[16] = '{mk(CL, 17'h11235, X1), NP, NP, NP, 3'h0, 2'h0};
    rows[17] = '{mk(CL, 17'h19235, X1), NP, NP, NP, 3'h0, 2'h1};
    rows[18] = '{ins(LD, X0), mk(CS, 17'h11234, X1), NP, NP, 3'h1, 2'h1};
    rows[19] = '{ins(LD, X0), ins(CO, Y1), ins(SE, X1), NP, 3'h1, 2'h2};
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    // Out of reset the evaluator is idle with every image cleared
    check("reset state", 32'({busy, done, stk_err, rng_err}), 32'h0);
    check("reset image", 32'(|{out_img, phys_out, mem_bits}), 32'h0);
    // Ordinary rungs; output 1 is only written by the midline row
    foreach (rows[r]) begin
      in_img[2:0] = rows[r].img;
      q = '{ins(RS, X0), rows[r].i0, rows[r].i1, rows[r].i2, rows[r].i3,
            ins(CO, Y0)};
      scan(0);
      check("row outputs", 32'(out_img[1:0]), 32'(rows[r].y));
    end
    // Full stack folded by seven merges, then a second rung from empty
    in_img[2:0] = 3'h1;
    q = '{ins(RS, X0), ins(LD, X0)};
    repeat (7) q.push_back(ins(LD, X1));
    repeat (7) q.push_back(ins(MP, X0));
    q = {q, ins(CO, 10'h102), ins(RS, X0), ins(LN, X1), ins(CO, 10'h105),
         ins(CO, 10'h203)};
    scan(0);
    check("deep stack", 32'(out_img[2]), 32'h00000001);
    check("relay coil", 32'(mem_bits[3]), 32'h00000001);
    check("fresh rung", 32'(out_img[5]), 32'h00000001);
    check("no overflow", 32'(stk_err), 32'h00000000);
    // Ninth push overflows; the rung must not reach its coil
    q = '{ins(RS, X0)};
    repeat (9) q.push_back(ins(LD, X0));
    q.push_back(ins(CO, 10'h106));
    scan(-1);
    check("overflow flag", 32'(stk_err), 32'h00000001);
    check("overflow coil", 32'(out_img[6]), 32'h00000000);
    // Pin differs from image; synchroniser needs a few cycles to settle
    in_img[0] = 1'b0;
    phys_in[0] = 1'b1;
    repeat (4) @(negedge clk);
    q = '{ins(RS, X0), ins(IL, X0), ins(CO, 10'h103), ins(RS, X0),
          ins(LD, X0), ins(CO, 10'h107), ins(RS, X0), ins(IL, X0),
          ins(IS, X0), ins(IC, 10'h108)};
    scan(4);
    check("flag cleared", 32'(stk_err), 32'h00000000);
    check("imm read", 32'(out_img[3]), 32'h00000001);
    check("image kept", 32'(out_img[7]), 32'h00000000);
    check("imm pin", 32'(phys_out[8]), 32'h00000001);
    check("imm image", 32'(out_img[8]), 32'h00000001);
    phys_in[0] = 1'b0;
    repeat (4) @(negedge clk);
    scan(4);
    check("imm reread", 32'(out_img[3]), 32'h00000000);
    check("imm pin low", 32'(phys_out[8]), 32'h00000000);
    // Timer space ends at the last legal point; one past it is refused
    q = '{ins(RS, X0), ins(LD, 10'h37f), ins(CO, 10'h109)};
    scan(0);
    check("range edge", 32'(rng_err), 32'h00000000);
    q[1] = ins(LD, 10'h380);
    scan(-1);
    check("range over", 32'(rng_err), 32'h00000001);
    check("after end", 32'(out_img[4]), 32'h00000000);
    // Reset in mid-scan drops busy and the sticky range flag at once
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    repeat (4) @(negedge clk);
    rst_n = 1'b0;
    @(negedge clk);
    check("mid reset", 32'({busy, rng_err}), 32'h00000000);
    rst_n = 1'b1;
    repeat (2) @(negedge clk);
    check("no false start", 32'(busy), 32'h00000000);
    wrap_up();
  end
endmodule : tb_bre_evaluator
